// ---- verilog/rtw_map.svh ----
// Register offsets, field positions and reset values of the trim, wake-up and PLL limit block.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef RTW_MAP_SVH
`define RTW_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RTW_ADDR_OSC_CAL       32'h400E0510
`define RTW_ADDR_WAKE_ENABLE   32'h400E0514
`define RTW_ADDR_WAKE_DISABLE  32'h400E0518
`define RTW_ADDR_WAKE_STATE    32'h400E051C
`define RTW_ADDR_WAKE_ACTIVITY 32'h400E0520
`define RTW_ADDR_PLL_LIMIT     32'h400E0530

// ----------------------------------------------------------------------------
// Calibration register fields
// ----------------------------------------------------------------------------
`define RTW_TRIM_W        7
`define RTW_CAL_LOW_LSB   0
`define RTW_SEL_LOW_BIT   7
`define RTW_CAL_MID_LSB   8
`define RTW_SEL_MID_BIT   15
`define RTW_CAL_HIGH_LSB  16
`define RTW_SEL_HIGH_BIT  23
`define RTW_OSC_CAL_MASK  32'h00FFFFFF
`define RTW_OSC_CAL_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Wake-up register fields
// ----------------------------------------------------------------------------
`define RTW_PID_LSB       8
`define RTW_PID_MSB       29
`define RTW_PID_W         22
`define RTW_WAKE_MASK     32'h3FFFFF00
`define RTW_PID_SERIAL0   8
`define RTW_PID_SERIAL1   9
`define RTW_PID_TWOWIRE0  19
`define RTW_WAKE_CAPABLE  32'h00080300

// ----------------------------------------------------------------------------
// PLL limit fields
// ----------------------------------------------------------------------------
`define RTW_MUL_W         11
`define RTW_MUL_MSB       10
`define RTW_PLL_MAX_RESET 11'h7FF

`endif

// ---- verilog/rtw_pkg.sv ----
// Types shared by the trim, wake-up and PLL limit block.
// Assumes rtw_map.svh is on the include path.
`include "rtw_map.svh"

package rtw_pkg;

    // Register bus request from software
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rtw_bus_req_s;

    // Trim word applied to the RC oscillator for one frequency
    typedef logic [`RTW_TRIM_W-1:0] rtw_trim_t;

    // Trims sent to the oscillator
    typedef struct packed {
        rtw_trim_t low;
        rtw_trim_t mid;
        rtw_trim_t high;
    } rtw_trims_s;

    // Phase of the PLL limit checker
    typedef enum logic [1:0] {
        RTW_LIM_IDLE,
        RTW_LIM_CHECK,
        RTW_LIM_DONE
    } rtw_lim_state_e;

endpackage

// ---- verilog/rtw_pll_limit.sv ----
// PLL multiplier saturation and guarded maximum update.
// Assumes a requested multiplier from the clock generator on sys_clk.
`timescale 1ns/1ps
`include "rtw_map.svh"

module rtw_pll_limit (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    input  wire logic                     clk_en,
    // Requested multiplier and write request
    input  wire logic [`RTW_MUL_MSB:0]    pll_requested_multiplier,
    input  wire logic                     max_wr,
    input  wire logic [`RTW_MUL_MSB:0]    max_wdata,
    // Results
    output logic      [`RTW_MUL_MSB:0]    pll_max_multiplier,
    output logic      [`RTW_MUL_MSB:0]    pll_mul_out,
    output logic                          saturating,
    output logic                          max_rejected
);

    logic [`RTW_MUL_MSB:0] next_max;
    logic [`RTW_MUL_MSB:0] next_mul_out;
    logic                  next_saturating;
    logic                  next_rejected;
    logic                  sat_now;

    // Saturation and write acceptance
    always_comb begin
        sat_now         = (pll_requested_multiplier > pll_max_multiplier);
        next_max        = pll_max_multiplier;
        next_rejected   = 1'b0;
        next_saturating = sat_now;
        next_mul_out    = sat_now ? pll_max_multiplier : pll_requested_multiplier;
        if (max_wr) begin
            if (sat_now || (max_wdata < pll_requested_multiplier)) begin
                next_rejected = 1'b1;
            end else begin
                next_max = max_wdata;
            end
        end
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pll_max_multiplier <= `RTW_PLL_MAX_RESET;
            pll_mul_out        <= '0;
            saturating         <= 1'b0;
            max_rejected       <= 1'b0;
        end else if (clk_en) begin
            pll_max_multiplier <= next_max;
            pll_mul_out        <= next_mul_out;
            saturating         <= next_saturating;
            max_rejected       <= next_rejected;
        end
    end

endmodule

// ---- verilog/rtw_ctrl.sv ----
// Top of the trim, wake-up and PLL limit block.
// Assumes write protect, factory trims and peripheral signals come from sys_clk logic,
// except wake_clear and periph_active, which come from peripherals and are synchronised.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "rtw_map.svh"

module rtw_ctrl (
    // Clock, reset, enable
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    input  wire logic                      clk_en,
    // Register bus
    input  wire rtw_pkg::rtw_bus_req_s     bus_req,
    output logic      [31:0]               rdata,
    // Write protection from the controller
    input  wire logic                      write_protect_enable,
    // Factory trims from flash
    input  wire rtw_pkg::rtw_trims_s       factory_trims,
    // Trims to the oscillator
    output rtw_pkg::rtw_trims_s            rc_trims,
    // Peripheral wake-up signals, indexed by peripheral bit
    input  wire logic [31:0]               wake_clear,
    input  wire logic [31:0]               periph_active,
    output logic      [31:0]               wake_enabled,
    // PLL multiplier
    input  wire logic [`RTW_MUL_MSB:0]     pll_requested_multiplier,
    output logic      [`RTW_MUL_MSB:0]     pll_mul_out,
    output logic                           pll_saturating,
    output logic                           pll_max_rejected
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Address compare for a write or read
    function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // Trim choice between factory and user value
    function automatic rtw_pkg::rtw_trim_t pick(input logic sel,
                                                 input rtw_pkg::rtw_trim_t user,
                                                 input rtw_pkg::rtw_trim_t fact);
        pick = sel ? user : fact;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [31:0]              osc_cal;
    logic [31:0]              next_osc_cal;
    logic [31:0]              wake_en;
    logic [31:0]              next_wake_en;
    logic [31:0]              clr_meta;
    logic [31:0]              clr_sync;
    logic [31:0]              clr_prev;
    logic [31:0]              act_meta;
    logic [31:0]              act_sync;
    logic [31:0]              next_rdata;
    rtw_pkg::rtw_trims_s      next_trims;
    logic                     wr_ok;
    logic                     max_wr;
    logic [`RTW_MUL_MSB:0]    pll_max;
    logic [31:0]              clr_rise;

    // Writes pass only while protection is off
    assign wr_ok  = bus_req.wr && !write_protect_enable;
    assign max_wr = wr_ok && hit(bus_req.addr, `RTW_ADDR_PLL_LIMIT);

    // ------------------------------------------------------------------------
    // Synchronisers for peripheral signals
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            clr_meta <= 32'h00000000;
            clr_sync <= 32'h00000000;
            clr_prev <= 32'h00000000;
            act_meta <= 32'h00000000;
            act_sync <= 32'h00000000;
        end else if (clk_en) begin
            clr_meta <= wake_clear;
            clr_sync <= clr_meta;
            clr_prev <= clr_sync;
            act_meta <= periph_active;
            act_sync <= act_meta;
        end
    end

    // Rising edge of a peripheral clear request
    assign clr_rise = clr_sync & ~clr_prev;

    // ------------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------------
    always_comb begin
        next_osc_cal = osc_cal;
        if (wr_ok && hit(bus_req.addr, `RTW_ADDR_OSC_CAL)) begin
            next_osc_cal = bus_req.wdata & `RTW_OSC_CAL_MASK;
        end
        // Peripheral clear first, so a software enable in the same cycle wins
        next_wake_en = wake_en & ~clr_rise;
        if (wr_ok && hit(bus_req.addr, `RTW_ADDR_WAKE_DISABLE)) begin
            next_wake_en = next_wake_en & ~(bus_req.wdata & `RTW_WAKE_CAPABLE);
        end
        if (wr_ok && hit(bus_req.addr, `RTW_ADDR_WAKE_ENABLE)) begin
            next_wake_en = next_wake_en | (bus_req.wdata & `RTW_WAKE_CAPABLE);
        end
        next_wake_en = next_wake_en & `RTW_WAKE_CAPABLE;
    end

    // Trim selection per frequency
    always_comb begin
        next_trims.low  = pick(osc_cal[`RTW_SEL_LOW_BIT],
                               osc_cal[`RTW_CAL_LOW_LSB +: `RTW_TRIM_W], factory_trims.low);
        next_trims.mid  = pick(osc_cal[`RTW_SEL_MID_BIT],
                               osc_cal[`RTW_CAL_MID_LSB +: `RTW_TRIM_W], factory_trims.mid);
        next_trims.high = pick(osc_cal[`RTW_SEL_HIGH_BIT],
                               osc_cal[`RTW_CAL_HIGH_LSB +: `RTW_TRIM_W], factory_trims.high);
    end

    // Read data multiplexer
    always_comb begin
        next_rdata = 32'h00000000;
        if (bus_req.rd) begin
            if (hit(bus_req.addr, `RTW_ADDR_OSC_CAL)) begin
                next_rdata = osc_cal;
            end else if (hit(bus_req.addr, `RTW_ADDR_WAKE_STATE)) begin
                next_rdata = wake_en & `RTW_WAKE_MASK;
            end else if (hit(bus_req.addr, `RTW_ADDR_WAKE_ACTIVITY)) begin
                next_rdata = act_sync & `RTW_WAKE_CAPABLE;
            end else if (hit(bus_req.addr, `RTW_ADDR_PLL_LIMIT)) begin
                next_rdata = {{(32 - `RTW_MUL_W){1'b0}}, pll_max};
            end else begin
                next_rdata = 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            osc_cal      <= `RTW_OSC_CAL_RESET;
            wake_en      <= 32'h00000000;
            wake_enabled <= 32'h00000000;
            rc_trims     <= '0;
            rdata        <= 32'h00000000;
        end else if (clk_en) begin
            osc_cal      <= next_osc_cal;
            wake_en      <= next_wake_en;
            wake_enabled <= next_wake_en;
            rc_trims     <= next_trims;
            rdata        <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // PLL limit
    // ------------------------------------------------------------------------
    rtw_pll_limit u_pll_limit (
        .sys_clk                  (sys_clk),
        .nrst                     (nrst),
        .clk_en                   (clk_en),
        .pll_requested_multiplier (pll_requested_multiplier),
        .max_wr                   (max_wr),
        .max_wdata                (bus_req.wdata[`RTW_MUL_MSB:0]),
        .pll_max_multiplier       (pll_max),
        .pll_mul_out              (pll_mul_out),
        .saturating               (pll_saturating),
        .max_rejected             (pll_max_rejected)
    );

endmodule

// ---- tb/rtw_ctrl_assertions.sv ----
// Checker for the trim, wake-up and PLL limit block.
// Assumes it is bound to rtw_ctrl; write checks only count cycles with clk_en high.
`timescale 1ns/1ps
`include "rtw_map.svh"

module rtw_ctrl_checker (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  nrst,
    input wire logic                  clk_en,
    // Bus and protection
    input wire rtw_pkg::rtw_bus_req_s bus_req,
    input wire logic [31:0]           rdata,
    input wire logic                  write_protect_enable,
    // Wake-up and PLL results
    input wire logic [31:0]           wake_enabled,
    input wire logic [`RTW_MUL_MSB:0] pll_requested_multiplier,
    input wire logic [`RTW_MUL_MSB:0] pll_mul_out,
    input wire logic                  pll_saturating,
    input wire logic                  pll_max_rejected
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Bus write in a clk_en cycle to one address under a given protection level
    sequence s_wr(a, p);
        bus_req.wr && clk_en && write_protect_enable == p && bus_req.addr == a;
    endsequence
    // Read of one address one cycle ago
    sequence s_rd(a);
        $past(bus_req.rd) && $past(bus_req.addr) == a;
    endsequence
    // Request held since the registers last loaded
    sequence s_steady;
        $past(nrst) && $stable(pll_requested_multiplier);
    endsequence

    chk_wp_no_enable: assert property (s_wr(`RTW_ADDR_WAKE_ENABLE, 1'b1) |=>
        (wake_enabled & ~$past(wake_enabled)) == 32'h0) else $error("protected enable write took effect");
    chk_enable_sets: assert property (s_wr(`RTW_ADDR_WAKE_ENABLE, 1'b0) |=>
        (wake_enabled & $past(bus_req.wdata) & `RTW_WAKE_CAPABLE) == ($past(bus_req.wdata) & `RTW_WAKE_CAPABLE))
        else $error("enable write missed a bit");
    chk_disable_clears: assert property (s_wr(`RTW_ADDR_WAKE_DISABLE, 1'b0) |=>
        (wake_enabled & $past(bus_req.wdata)) == 32'h0) else $error("disable write left a bit set");
    chk_capable_only: assert property ((wake_enabled & ~`RTW_WAKE_CAPABLE) == 32'h0)
        else $error("wake enable on an incapable peripheral");
    chk_sat_clamps: assert property (s_steady ##0 pll_saturating |-> pll_mul_out < pll_requested_multiplier)
        else $error("saturated output not below request");
    chk_sat_passes: assert property (s_steady ##0 !pll_saturating |-> pll_mul_out == pll_requested_multiplier)
        else $error("unsaturated output differs from request");
    chk_reject_pulse: assert property (pll_max_rejected |->
        $past(bus_req.wr && bus_req.addr == `RTW_ADDR_PLL_LIMIT) ##1 !pll_max_rejected)
        else $error("reject pulse without limit write or too long");
    chk_wo_read_zero: assert property (s_rd(`RTW_ADDR_WAKE_ENABLE) or s_rd(`RTW_ADDR_WAKE_DISABLE) |->
        rdata == 32'h0) else $error("write-only register read nonzero");
    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    chk_state_mirror: assert property (s_rd(`RTW_ADDR_WAKE_STATE) |-> rdata == $past(wake_enabled))
        else $error("state read differs from enables");
    chk_activity_mask: assert property (s_rd(`RTW_ADDR_WAKE_ACTIVITY) |->
        (rdata & ~`RTW_WAKE_CAPABLE) == 32'h0) else $error("activity bit of incapable peripheral");
endmodule

bind rtw_ctrl rtw_ctrl_checker i_rtw_ctrl_checker (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .bus_req(bus_req), .rdata(rdata), .write_protect_enable(write_protect_enable), .wake_enabled(wake_enabled),
    .pll_requested_multiplier(pll_requested_multiplier), .pll_mul_out(pll_mul_out),
    .pll_saturating(pll_saturating), .pll_max_rejected(pll_max_rejected));

// ---- tb/rtw_ctrl_tb.sv ----
// Self-checking bench for the trim, wake-up and PLL limit block.
// Assumes the design and checker are compiled before it.
`timescale 1ns/1ps
`include "rtw_map.svh"

module rtw_ctrl_tb;
    localparam logic [31:0] A_CAL = `RTW_ADDR_OSC_CAL;
    localparam logic [31:0] A_EN  = `RTW_ADDR_WAKE_ENABLE;
    localparam logic [31:0] A_DIS = `RTW_ADDR_WAKE_DISABLE;
    localparam logic [31:0] A_ST  = `RTW_ADDR_WAKE_STATE;
    localparam logic [31:0] A_ACT = `RTW_ADDR_WAKE_ACTIVITY;
    localparam logic [31:0] A_LIM = `RTW_ADDR_PLL_LIMIT;

    logic                  sys_clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  clk_en = 1'b1;
    rtw_pkg::rtw_bus_req_s bus_req = '0;
    logic                  wp = 1'b0;
    rtw_pkg::rtw_trims_s   fact = '{low: 7'h11, mid: 7'h22, high: 7'h33};
    logic [31:0]           wake_clear = '0;
    logic [31:0]           periph_active = '0;
    logic [10:0]           req_mul = 11'h064;
    logic [31:0]           rdata;
    logic [31:0]           wake_enabled;
    rtw_pkg::rtw_trims_s   rc_trims;
    logic [10:0]           mul_out;
    logic                  sat;
    logic                  rej;
    int                    bad_count = 0;
    int                    n_compared = 0;
    int                    cycles = 0;
    int                    rej_seen = 0;

    // Device under test
    rtw_ctrl i_rtw_ctrl (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata),
        .write_protect_enable(wp), .factory_trims(fact), .rc_trims(rc_trims), .wake_clear(wake_clear),
        .periph_active(periph_active), .wake_enabled(wake_enabled), .pll_requested_multiplier(req_mul),
        .pll_mul_out(mul_out), .pll_saturating(sat), .pll_max_rejected(rej));

    // Clock
    always #5 sys_clk = ~sys_clk;

    // Cycle ceiling and reject pulse count
    always @(posedge sys_clk) begin
        cycles++;
        if (rej) rej_seen++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 compare(rdata, exp);
    endtask

    task automatic settle();
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(A_CAL, 32'h0);
        rd(A_LIM, 32'h7FF);
        wr(A_CAL, 32'hFFD52A83);
        rd(A_CAL, 32'h00D52A83);
        compare(32'(rc_trims), {11'h0, 7'h03, 7'h22, 7'h55});
        wr(A_CAL, 32'h0055AA03);
        rd(A_CAL, 32'h0055AA03);
        compare(32'(rc_trims), {11'h0, 7'h11, 7'h2A, 7'h33});
        @(posedge sys_clk);
        wp <= 1'b1;
        wr(A_CAL, 32'h0);
        wr(A_EN, 32'hFFFFFFFF);
        wr(A_LIM, 32'h100);
        rd(A_CAL, 32'h0055AA03);
        rd(A_ST, 32'h0);
        rd(A_LIM, 32'h7FF);
        @(posedge sys_clk);
        wp     <= 1'b0;
        clk_en <= 1'b0;
        wr(A_CAL, 32'h0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(A_CAL, 32'h0055AA03);
        wr(A_EN, 32'hFFFFFFFF);
        rd(A_ST, 32'h00080300);
        rd(A_EN, 32'h0);
        rd(A_DIS, 32'h0);
        wr(A_DIS, 32'h00000200);
        wr(A_EN, 32'h0);
        rd(A_ST, 32'h00080100);
        @(posedge sys_clk);
        wake_clear <= 32'h00000100;
        settle();
        compare(wake_enabled, 32'h00080000);
        @(posedge sys_clk);
        wake_clear    <= '0;
        periph_active <= '1;
        settle();
        rd(A_ACT, 32'h00080300);
        @(posedge sys_clk);
        periph_active <= '0;
        rd(32'h400E0524, 32'h0);
        wr(A_LIM, 32'h032);
        rd(A_LIM, 32'h7FF);
        compare(32'(rej_seen), 32'h1);
        wr(A_LIM, 32'h0C8);
        rd(A_LIM, 32'h0C8);
        @(posedge sys_clk);
        req_mul <= 11'h12C;
        settle();
        compare(32'({sat, mul_out}), 32'h8C8);
        wr(A_LIM, 32'h190);
        rd(A_LIM, 32'h0C8);
        compare(32'(rej_seen), 32'h2);
        @(posedge sys_clk);
        req_mul <= 11'h0C8;
        settle();
        compare(32'({sat, mul_out}), 32'h0C8);
        conclude();
    end
endmodule
